// [shared/iocsd_regs.svh]
// Constants for the I/O chip-select decoder
`ifndef IOCSD_REGS_SVH
`define IOCSD_REGS_SVH
`define IOCSD_IO_SPACE_BYTES 17'h10000
`define IOCSD_DIRECT_PORT_MAX 16'h00FF
`define IOCSD_BYTE_BASE 16'h0080
`define IOCSD_WORD_BASE 16'h00C0
`define IOCSD_CONV_BASE 16'h00E0
`define IOCSD_MEM_CONV_BASE 20'hE0000
`define IOCSD_MEM_RESET_LO 20'hFFFF0
`define IOCSD_MEM_VECT_HI 20'h003FF
`define IOCSD_NUM_PAIRS 4
`endif

// [shared/iocsd_pkg.sv]
// Types for the I/O chip-select decoder
package iocsd_pkg;
	typedef enum logic [3:0] {
		IOCSD_MODE_SPLIT = 4'h1,
		IOCSD_MODE_BYTEONLY = 4'h2,
		IOCSD_MODE_SINGLE = 4'h4,
		IOCSD_MODE_CONV = 4'h8
	} iocsd_mode_t;
	typedef struct packed {
		logic [19:0] addr;
		logic upper_byte_enable_n;
		logic rd_n;
		logic wr_n;
		logic mem_io_n;
	} iocsd_bus_t;
	typedef struct packed {
		logic mem_rd_n;
		logic mem_wr_n;
		logic io_rd_n;
		logic io_wr_n;
	} iocsd_cmd_t;
	typedef struct packed {
		logic [3:0] even_cs_n;
		logic [3:0] odd_cs_n;
		logic word_cs_n;
		logic conv_cs_n;
		logic conv_hi_lane;
		iocsd_cmd_t cmd;
	} iocsd_out_t;
	typedef struct packed {
		iocsd_out_t outs;
	} iocsd_state_t;
endpackage

// [hw/iocsd_decoder.sv]
// I/O chip-select decoder for byte and word peripherals
// Overview of operation
// - I/O space of 64K byte ports decoded apart from memory space
// - Ports 0 to 255 direct; ports above 255 select no device
// - Odd byte transfers use upper data lane, even ones lower lane
// - Split mode: even word transfer selects both even and odd device
// - Odd word transfers become two byte cycles, seen as byte accesses
// - Single mode: even word transfer selects only the even device
// - Bus converter steers both lanes onto one byte bus, consecutive addresses
// - Distinct commands fix each peripheral's address space
`timescale 1ns/1ps
`include "iocsd_regs.svh"
module iocsd_decoder
	import iocsd_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Latched processor bus, same clock
	input iocsd_bus_t bus,
	input iocsd_mode_t mode,
	// Selects and commands
	output iocsd_out_t outs
);
	iocsd_state_t st_r;
	iocsd_state_t st_nxt;

	// Block match over a decode block of eight bytes, upper address nibble zero
	function automatic logic blk_hit(input logic [19:0] a, input logic [15:0] base);
		blk_hit = (a[19:16] == 4'h0) && (a[15:3] == base[15:3]);
	endfunction

	logic is_io;
	logic is_mem;
	logic access;
	logic a0;
	logic ube;
	logic word_xfer;
	logic byte_hit;
	logic mem_safe;
	logic [1:0] pair;
	logic word_hit;
	logic conv_hit;

	always_comb begin
		is_io = ~bus.mem_io_n;
		is_mem = bus.mem_io_n;
		access = ~bus.rd_n | ~bus.wr_n;
		a0 = bus.addr[0];
		ube = ~bus.upper_byte_enable_n;
		word_xfer = ~a0 & ube;
		pair = bus.addr[2:1];
		byte_hit = is_io && access && blk_hit(bus.addr, `IOCSD_BYTE_BASE);
		word_hit = is_io && access && blk_hit(bus.addr, `IOCSD_WORD_BASE);
		mem_safe = (bus.addr > `IOCSD_MEM_VECT_HI) && (bus.addr < `IOCSD_MEM_RESET_LO);
		conv_hit = is_mem && access && mem_safe && (bus.addr[19:16] == 4'(`IOCSD_MEM_CONV_BASE >> 16));
		st_nxt = st_r;
		st_nxt.outs.even_cs_n = 4'hF;
		st_nxt.outs.odd_cs_n = 4'hF;
		st_nxt.outs.word_cs_n = 1'b1;
		st_nxt.outs.conv_cs_n = 1'b1;
		st_nxt.outs.conv_hi_lane = a0;
		// Four separate commands from shared strobes
		st_nxt.outs.cmd.mem_rd_n = ~(is_mem & ~bus.rd_n);
		st_nxt.outs.cmd.mem_wr_n = ~(is_mem & ~bus.wr_n);
		st_nxt.outs.cmd.io_rd_n = ~(is_io & ~bus.rd_n);
		st_nxt.outs.cmd.io_wr_n = ~(is_io & ~bus.wr_n);
		if (byte_hit) begin
			unique case (mode)
				IOCSD_MODE_SPLIT: begin
					st_nxt.outs.even_cs_n[pair] = a0;
					st_nxt.outs.odd_cs_n[pair] = ~ube;
				end
				IOCSD_MODE_BYTEONLY: begin
					st_nxt.outs.even_cs_n[pair] = ~(~a0 & ~ube);
					st_nxt.outs.odd_cs_n[pair] = ~(a0 & ube);
				end
				IOCSD_MODE_SINGLE: begin
					st_nxt.outs.even_cs_n[pair] = a0;
					st_nxt.outs.odd_cs_n[pair] = ~(a0 & ube);
				end
				IOCSD_MODE_CONV: begin
				end
				default: begin
				end
			endcase
		end
		if (word_hit && word_xfer)
			st_nxt.outs.word_cs_n = 1'b0;
		if (mode == IOCSD_MODE_CONV && conv_hit)
			st_nxt.outs.conv_cs_n = 1'b0;
		if (!reset_n) begin
			st_nxt.outs.even_cs_n = 4'hF;
			st_nxt.outs.odd_cs_n = 4'hF;
			st_nxt.outs.word_cs_n = 1'b1;
			st_nxt.outs.conv_cs_n = 1'b1;
			st_nxt.outs.conv_hi_lane = 1'b0;
			st_nxt.outs.cmd = 4'hF;
		end
	end

	always_ff @(posedge clk) begin
		st_r <= st_nxt;
	end

	assign outs = st_r.outs;

	// Reset and idle bus
	AST_RESET_IDLE: assert property (@(posedge clk)
		!reset_n |=> (outs.even_cs_n == 4'hF && outs.odd_cs_n == 4'hF && outs.word_cs_n &&
		outs.conv_cs_n && outs.cmd == 4'hF && !outs.conv_hi_lane))
		else $error("outputs not idle after reset");

	AST_IDLE_NO_CS: assert property (@(posedge clk) disable iff (!reset_n)
		(bus.rd_n && bus.wr_n) |=>
		(outs.even_cs_n == 4'hF && outs.odd_cs_n == 4'hF && outs.word_cs_n && outs.conv_cs_n))
		else $error("select active without access");

	AST_IDLE_NO_CMD: assert property (@(posedge clk) disable iff (!reset_n)
		(bus.rd_n && bus.wr_n) |=> (outs.cmd == 4'hF))
		else $error("command active without access");

	// Address spaces
	AST_MEM_NO_IO_CS: assert property (@(posedge clk) disable iff (!reset_n)
		bus.mem_io_n |=> (outs.even_cs_n == 4'hF && outs.odd_cs_n == 4'hF && outs.word_cs_n))
		else $error("I/O select during memory cycle");

	AST_IO_NO_CONV: assert property (@(posedge clk) disable iff (!reset_n)
		!bus.mem_io_n |=> outs.conv_cs_n)
		else $error("memory select during I/O cycle");

	AST_HIGH_PORT: assert property (@(posedge clk) disable iff (!reset_n)
		(!bus.mem_io_n && bus.addr[15:0] > `IOCSD_DIRECT_PORT_MAX) |=>
		(outs.even_cs_n == 4'hF && outs.odd_cs_n == 4'hF && outs.word_cs_n))
		else $error("select for port beyond the direct range");

	// Byte lanes
	AST_SPLIT_WORD: assert property (@(posedge clk) disable iff (!reset_n)
		(byte_hit && mode == IOCSD_MODE_SPLIT && word_xfer) |=>
		(outs.even_cs_n[$past(pair)] == 1'b0 && outs.odd_cs_n[$past(pair)] == 1'b0))
		else $error("split word did not select both");

	AST_SPLIT_ODD: assert property (@(posedge clk) disable iff (!reset_n)
		(byte_hit && mode == IOCSD_MODE_SPLIT && a0 && ube) |=>
		(outs.odd_cs_n[$past(pair)] == 1'b0 && outs.even_cs_n == 4'hF))
		else $error("split odd byte selected the wrong device");

	AST_EVEN_BYTE: assert property (@(posedge clk) disable iff (!reset_n)
		(byte_hit && mode != IOCSD_MODE_CONV && !a0 && !ube) |=>
		(outs.even_cs_n[$past(pair)] == 1'b0 && outs.odd_cs_n == 4'hF))
		else $error("even byte did not select only the lower lane");

	AST_ODD_NO_EVEN: assert property (@(posedge clk) disable iff (!reset_n)
		(byte_hit && a0) |=> (outs.even_cs_n == 4'hF))
		else $error("odd byte selected a lower lane device");

	AST_BYTEONLY_WORD: assert property (@(posedge clk) disable iff (!reset_n)
		(byte_hit && mode == IOCSD_MODE_BYTEONLY && word_xfer) |=>
		(outs.even_cs_n == 4'hF && outs.odd_cs_n == 4'hF))
		else $error("byte-only decode selected on a word");

	AST_BYTEONLY_ODD: assert property (@(posedge clk) disable iff (!reset_n)
		(byte_hit && mode == IOCSD_MODE_BYTEONLY && a0 && ube) |=> (outs.odd_cs_n[$past(pair)] == 1'b0))
		else $error("byte-only decode missed an odd byte");

	AST_SINGLE_WORD: assert property (@(posedge clk) disable iff (!reset_n)
		(byte_hit && mode == IOCSD_MODE_SINGLE && word_xfer) |=>
		(outs.odd_cs_n == 4'hF && outs.even_cs_n[$past(pair)] == 1'b0))
		else $error("single mode selected odd on word");

	AST_ODD_NEEDS_UBE: assert property (@(posedge clk) disable iff (!reset_n)
		(byte_hit && !ube) |=> (outs.odd_cs_n == 4'hF))
		else $error("odd select without upper byte enable");

	// Each pair answers only to its own address bits two and one
	for (genvar p = 0; p < `IOCSD_NUM_PAIRS; p++) begin : g_pair
		AST_PAIR_EVEN: assert property (@(posedge clk) disable iff (!reset_n)
			!outs.even_cs_n[p] |-> ($past(pair) == 2'(p)))
			else $error("even select on the wrong pair");
		AST_PAIR_ODD: assert property (@(posedge clk) disable iff (!reset_n)
			!outs.odd_cs_n[p] |-> ($past(pair) == 2'(p)))
			else $error("odd select on the wrong pair");
	end

	// Word device
	AST_WORD_ONLY: assert property (@(posedge clk) disable iff (!reset_n)
		(a0 || !ube) |=> outs.word_cs_n)
		else $error("word device selected on byte transfer");

	AST_WORD_SEL: assert property (@(posedge clk) disable iff (!reset_n)
		(word_hit && word_xfer) |=> !outs.word_cs_n)
		else $error("word device not selected on a word transfer");

	// Commands
	AST_IO_CMD: assert property (@(posedge clk) disable iff (!reset_n)
		(is_io && !bus.wr_n) |=> (!outs.cmd.io_wr_n && outs.cmd.mem_wr_n))
		else $error("I/O write command wrong");

	AST_MEM_CMD: assert property (@(posedge clk) disable iff (!reset_n)
		(is_mem && !bus.rd_n) |=> (!outs.cmd.mem_rd_n && outs.cmd.io_rd_n))
		else $error("memory read command wrong");

	// Converter and lane steering
	AST_CONV_SAFE: assert property (@(posedge clk) disable iff (!reset_n)
		!mem_safe |=> outs.conv_cs_n)
		else $error("select in reserved memory region");

	AST_CONV_SEL: assert property (@(posedge clk) disable iff (!reset_n)
		(mode == IOCSD_MODE_CONV && conv_hit) |=> !outs.conv_cs_n)
		else $error("converter not selected in its window");

	AST_CONV_NO_BYTE: assert property (@(posedge clk) disable iff (!reset_n)
		(mode == IOCSD_MODE_CONV) |=> (outs.even_cs_n == 4'hF && outs.odd_cs_n == 4'hF))
		else $error("byte select while the converter is in use");

	AST_LANE: assert property (@(posedge clk) disable iff (!reset_n)
		1'b1 |=> (outs.conv_hi_lane == $past(a0)))
		else $error("lane steering does not follow address bit zero");
endmodule

// [tb/iocsd_periph.sv]
// Byte peripheral on pair zero of the lower lane
`timescale 1ns/1ps
module iocsd_periph
	import iocsd_pkg::*;
(
	// Decoder outputs
	input iocsd_out_t outs,
	// Peripheral takes part in a transfer
	output logic hit
);
	assign hit = !outs.even_cs_n[0] && !(outs.cmd.io_rd_n && outs.cmd.io_wr_n);
endmodule

// [tb/testbench.sv]
// Random and corner checks of the I/O chip-select decoder
`timescale 1ns/1ps
module testbench
	import iocsd_pkg::*;
;
	logic clk = 0;
	logic reset_n = 0;
	iocsd_bus_t bus = '1;
	iocsd_mode_t mode = IOCSD_MODE_SPLIT;
	iocsd_out_t outs;
	iocsd_out_t e;
	logic hit;
	int fail_count = 0;
	int samples_checked = 0;
	int seed = 32'hD23A722D;
	logic [31:0] r;
	logic [19:0] cor [8] = '{20'h00082, 20'h00087, 20'h0007F, 20'hE0000, 20'h000C0, 20'h000C1, 20'h00088, 20'hFFFF0};
	iocsd_decoder DUT (.clk(clk), .reset_n(reset_n), .bus(bus), .mode(mode), .outs(outs));
	iocsd_periph PEER (.outs(outs), .hit(hit));
	initial forever #20 clk = ~clk;
	task chk(string n, logic [7:0] x, logic [7:0] g);
		samples_checked++;
		if (g !== x) begin
			fail_count++;
			$display("BAD %s exp %h got %h", n, x, g);
		end
	endtask
	task results;
		$display("checked %0d errors %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	function automatic iocsd_out_t exp_f(iocsd_bus_t b, iocsd_mode_t m);
		iocsd_out_t o;
		logic acc, a0, u, bk, wk;
		o = '1;
		o.conv_hi_lane = b.addr[0];
		acc = !(b.rd_n && b.wr_n);
		a0 = b.addr[0];
		u = !b.upper_byte_enable_n;
		bk = acc && !b.mem_io_n && m != IOCSD_MODE_CONV && b.addr[15:3] == 13'h0010;
		wk = acc && !b.mem_io_n && b.addr[15:3] == 13'h0018;
		o.cmd = {b.rd_n | !b.mem_io_n, b.wr_n | !b.mem_io_n, b.rd_n | b.mem_io_n, b.wr_n | b.mem_io_n};
		o.even_cs_n[b.addr[2:1]] = !(bk && !a0 && (m != IOCSD_MODE_BYTEONLY || !u));
		o.odd_cs_n[b.addr[2:1]] = !(bk && u && (m == IOCSD_MODE_SPLIT || a0));
		o.word_cs_n = !(wk && !a0 && u);
		o.conv_cs_n = !(acc && b.mem_io_n && m == IOCSD_MODE_CONV && b.addr[19:16] == 4'hE);
		return o;
	endfunction
	initial begin
		repeat (8) @(negedge clk);
		reset_n = 1'h1;
		chk("reset", 8'h01, {7'h0, outs === 15'h7FEF});
		for (int i = 0; i < 400; i++) begin
			r = $random(seed);
			bus.addr = i < 8 ? cor[i] : (r[20] ? {12'h000, r[7:0]} : r[19:0]);
			if (i >= 8 && r[20] && r[25])
				bus.addr[7:3] = {1'h1, r[26], 3'h0};
			bus.mem_io_n = i < 8 ? cor[i][19] : r[21];
			if (!bus.mem_io_n)
				bus.addr[19:16] = 4'h0;
			bus.upper_byte_enable_n = !bus.addr[0] && r[22];
			{bus.rd_n, bus.wr_n} = r[23] ? {r[24], 1'h1} : {1'h1, r[24]};
			mode = iocsd_mode_t'(4'h1 << i[1:0]);
			@(negedge clk);
			e = exp_f(bus, mode);
			chk("cmd", {4'h0, e.cmd}, {4'h0, outs.cmd});
			chk("byte", {e.even_cs_n, e.odd_cs_n}, {outs.even_cs_n, outs.odd_cs_n});
			chk("word", {7'h0, e.word_cs_n}, {7'h0, outs.word_cs_n});
			chk("conv", {7'h0, e.conv_cs_n}, {7'h0, outs.conv_cs_n});
			chk("lane", {7'h0, e.conv_hi_lane}, {7'h0, outs.conv_hi_lane});
			chk("peer", {7'h0, !e.even_cs_n[0] && !(e.cmd.io_rd_n && e.cmd.io_wr_n)}, {7'h0, hit});
		end
		results();
	end
	initial begin
		#100000;
		fail_count++;
		results();
	end
endmodule
